// file: verilog/adc_conversion_control.sv
// Conversion control: APB registers, start sources, timing sequencer,
// result coding. Assumes an APB master on pclk, an asynchronous convert
// pin and a comparator that settles within one pclk of dac_code.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_control (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Start sources
	input wire logic external_convert_pin,
	input wire logic logic_array_output,
	input wire logic general_timer_zero,
	input wire logic general_timer_one,
	// Analog front end
	input wire logic comparator_in,
	output logic [11:0] dac_code,
	output logic sample_hold,
	output logic [1:0] adc_mode,
	output logic pos_buffer_bypass,
	output logic neg_buffer_bypass,
	output logic [4:0] positive_channel_select,
	output logic [4:0] negative_channel_select,
	output logic [4:0] amplifier_gain_field,
	// Completion pulse
	output logic conversion_done
);
	sar_if sar ();

	logic [15:0] converter_control_reg; // Control word
	logic [31:0] conversion_result_reg; // Coded result
	logic done_flag_reg; // Sticky completion
	logic single_pending_reg; // Software single start
	logic [2:0] pin_sync_reg; // Convert pin synchroniser
	logic pin_level_reg; // Filtered convert pin
	adc_pkg::state_t state_reg; // Sequencer state
	logic [7:0] div_cnt_reg; // Converter clock divider
	logic [4:0] phase_cnt_reg; // Converter clocks in phase
	logic conv_temp_reg; // This sample is temperature
	logic start_reg; // Engine start pulse
	logic pready_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic done_pulse_reg;

	// Decoded controls
	adc_pkg::src_t src; // Start source
	adc_pkg::mode_t mode; // Input configuration
	logic [2:0] div_log; // Divider exponent in use
	logic [7:0] div_last; // Divider terminal count
	logic [4:0] acq_last; // Last acquisition clock
	logic tick; // One converter clock
	logic go; // Start request level
	logic apb_setup; // APB setup phase
	logic apb_done; // APB access completes
	logic wr_control; // Control write this edge
	logic end_conv; // Last clock of conversion

	assign src = adc_pkg::src_t'(converter_control_reg[
		adc_pkg::SRC_LSB +: 3]);
	assign mode = adc_pkg::mode_t'(converter_control_reg[
		adc_pkg::MODE_LSB +: 2]);

	////////////////////////////////////////////////////////////////
	// Result coding
	////////////////////////////////////////////////////////////////

	// Place a raw code in the result word for the given mode
	function automatic logic [31:0] code_result(
		input adc_pkg::mode_t m,
		input logic [11:0] c
	);
		logic [31:0] w;
		w = {4'h0, c, 16'h0000};
		if (m == adc_pkg::MODE_DIFF) begin
			w = {{5{~c[11]}}, c[10:0], 16'h0000};
			w = {w[31], w[31:1]};
		end
		return w;
	endfunction

	////////////////////////////////////////////////////////////////
	// Input synchronisers
	////////////////////////////////////////////////////////////////

	// Three stages; a level counts once the last two agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_sync_reg <= 3'h0;
			pin_level_reg <= 1'b0;
		end else begin
			pin_sync_reg <= {pin_sync_reg[1:0], external_convert_pin};
			if (pin_sync_reg[1] == pin_sync_reg[2]) begin
				pin_level_reg <= pin_sync_reg[2];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Start request
	////////////////////////////////////////////////////////////////

	always_comb begin
		case (src)
			adc_pkg::SRC_PIN: go = pin_level_reg;
			adc_pkg::SRC_LOGIC: go = logic_array_output;
			adc_pkg::SRC_TMR0: go = general_timer_zero;
			adc_pkg::SRC_TMR1: go = general_timer_one;
			adc_pkg::SRC_SINGLE: go = single_pending_reg;
			adc_pkg::SRC_CONT: go = 1'b1;
			default: go = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			single_pending_reg <= 1'b0;
		end else if (wr_control && pwdata[adc_pkg::SRC_LSB +: 3] ==
				3'(adc_pkg::SRC_SINGLE)) begin
			// New request wins over the consume
			single_pending_reg <= 1'b1;
		end else if (state_reg == adc_pkg::ST_IDLE &&
				src == adc_pkg::SRC_SINGLE && go) begin
			single_pending_reg <= 1'b0;
		end else if (src != adc_pkg::SRC_SINGLE) begin
			// Stale request dropped on source change
			single_pending_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Converter clock and timing
	////////////////////////////////////////////////////////////////

	assign div_log = conv_temp_reg ? adc_pkg::TEMP_DIV_LOG :
		converter_control_reg[adc_pkg::DIV_LSB +: 3];
	assign div_last = 8'((9'h001 << div_log) - 9'h001);
	assign acq_last = conv_temp_reg ?
		adc_pkg::TEMP_ACQ_CLOCKS - 5'h01 :
		(converter_control_reg[adc_pkg::ACQ_LSB +: 4] == 4'h0 ? 5'h00 :
		{1'b0, converter_control_reg[adc_pkg::ACQ_LSB +: 4]} - 5'h01);
	assign tick = state_reg != adc_pkg::ST_IDLE && div_cnt_reg == div_last;
	assign end_conv = state_reg == adc_pkg::ST_CONV && tick &&
		phase_cnt_reg == adc_pkg::EXTRA_CLOCKS - 5'h01;

	// Divider runs only while acquiring or converting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_reg <= 8'h00;
		end else if (state_reg == adc_pkg::ST_IDLE || tick) begin
			div_cnt_reg <= 8'h00;
		end else begin
			div_cnt_reg <= div_cnt_reg + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////
	// Sequencer
	////////////////////////////////////////////////////////////////

	// Acquire, run the trials, write the result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= adc_pkg::ST_IDLE;
			phase_cnt_reg <= 5'h00;
			conv_temp_reg <= 1'b0;
			start_reg <= 1'b0;
			sample_hold <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			case (state_reg)
				adc_pkg::ST_IDLE: begin
					if (go) begin
						state_reg <= adc_pkg::ST_ACQ;
						phase_cnt_reg <= 5'h00;
						conv_temp_reg <= positive_channel_select ==
							adc_pkg::TEMP_CHANNEL;
						sample_hold <= 1'b1;
					end
				end
				adc_pkg::ST_ACQ: begin
					if (tick) begin
						if (phase_cnt_reg == acq_last) begin
							// Hold the sample, start the trials
							state_reg <= adc_pkg::ST_CONV;
							phase_cnt_reg <= 5'h00;
							sample_hold <= 1'b0;
							start_reg <= 1'b1;
						end else begin
							phase_cnt_reg <= phase_cnt_reg + 5'h01;
						end
					end
				end
				adc_pkg::ST_CONV: begin
					if (end_conv) begin
						phase_cnt_reg <= 5'h00;
						if (go) begin
							state_reg <= adc_pkg::ST_ACQ;
							conv_temp_reg <= positive_channel_select ==
								adc_pkg::TEMP_CHANNEL;
							sample_hold <= 1'b1;
						end else begin
							state_reg <= adc_pkg::ST_IDLE;
							conv_temp_reg <= 1'b0;
						end
					end else if (tick) begin
						phase_cnt_reg <= phase_cnt_reg + 5'h01;
					end
				end
				default: begin
					state_reg <= adc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Engine hookup
	assign sar.start = start_reg;
	assign sar.tick = tick && state_reg == adc_pkg::ST_CONV;
	// Comparator is judged against our own trial flop within one pclk;
	// a synchroniser here would make each trial judge a stale code
	assign sar.comp = comparator_in;
	assign dac_code = sar.code;

	sar_engine u_sar (
		.pclk(pclk),
		.presetn(presetn),
		.sar(sar.eng)
	);

	////////////////////////////////////////////////////////////////
	// Result and completion
	////////////////////////////////////////////////////////////////

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conversion_result_reg <= 32'h0000_0000;
			done_flag_reg <= 1'b0;
			done_pulse_reg <= 1'b0;
		end else begin
			done_pulse_reg <= end_conv;
			if (end_conv) begin
				conversion_result_reg <= code_result(mode, sar.code);
				// Set wins over the read clear
				done_flag_reg <= 1'b1;
			end else if (apb_done && !pwrite &&
					paddr == adc_pkg::OFF_RESULT) begin
				done_flag_reg <= 1'b0;
			end
		end
	end

	assign conversion_done = done_pulse_reg;

	////////////////////////////////////////////////////////////////
	// APB registers
	////////////////////////////////////////////////////////////////

	assign apb_setup = psel && !penable;
	assign apb_done = psel && penable && pready_reg;
	assign wr_control = apb_done && pwrite &&
		paddr == adc_pkg::OFF_CONTROL;

	// One wait-free access; answer prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= apb_setup;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			if (apb_setup) begin
				if (paddr == adc_pkg::OFF_CONTROL) begin
					prdata_reg <= {16'h0000, converter_control_reg};
				end else if (paddr == adc_pkg::OFF_POS_CH) begin
					prdata_reg <= {27'h0, positive_channel_select};
				end else if (paddr == adc_pkg::OFF_NEG_CH) begin
					prdata_reg <= {27'h0, negative_channel_select};
				end else if (paddr == adc_pkg::OFF_RESULT) begin
					prdata_reg <= conversion_result_reg;
				end else if (paddr == adc_pkg::OFF_GAIN) begin
					prdata_reg <= {27'h0, amplifier_gain_field};
				end else if (paddr == adc_pkg::OFF_STATUS) begin
					prdata_reg <= {30'h0, state_reg != adc_pkg::ST_IDLE,
						done_flag_reg};
				end else begin
					// Unmapped address
					pslverr_reg <= 1'b1;
				end
			end
		end
	end

	assign pready = pready_reg;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			converter_control_reg <= adc_pkg::CONTROL_RST;
			positive_channel_select <= adc_pkg::CHANNEL_RST;
			negative_channel_select <= adc_pkg::CHANNEL_RST;
			amplifier_gain_field <= adc_pkg::GAIN_RST;
		end else if (apb_done && pwrite) begin
			if (paddr == adc_pkg::OFF_CONTROL) begin
				converter_control_reg <= pwdata[15:0];
			end else if (paddr == adc_pkg::OFF_POS_CH) begin
				positive_channel_select <= pwdata[4:0];
			end else if (paddr == adc_pkg::OFF_NEG_CH) begin
				negative_channel_select <= pwdata[4:0];
			end else if (paddr == adc_pkg::OFF_GAIN) begin
				amplifier_gain_field <= pwdata[4:0];
			end
		end
	end

	assign neg_buffer_bypass = converter_control_reg[adc_pkg::NEG_BYP_BIT];
	assign pos_buffer_bypass = converter_control_reg[adc_pkg::POS_BYP_BIT];
	assign adc_mode = converter_control_reg[adc_pkg::MODE_LSB +: 2];

	////////////////////////////////////////////////////////////////
	// Checks
	////////////////////////////////////////////////////////////////

	property p_single_start;
		@(posedge pclk) disable iff (!presetn)
		state_reg == adc_pkg::ST_IDLE && src == adc_pkg::SRC_SINGLE &&
			single_pending_reg |=> state_reg == adc_pkg::ST_ACQ
			&& !single_pending_reg;
	endproperty
	a_single_start: assert property (p_single_start)
		else $error("single start not taken");
	property p_done_flag;
		@(posedge pclk) disable iff (!presetn)
		end_conv |=> conversion_done && done_flag_reg;
	endproperty
	a_done_flag: assert property (p_done_flag)
		else $error("completion not flagged");
	property p_diff_sign;
		@(posedge pclk) disable iff (!presetn)
		end_conv && mode == adc_pkg::MODE_DIFF |=>
			conversion_result_reg[31:27] == {5{~$past(sar.code[11])}};
	endproperty
	a_diff_sign: assert property (p_diff_sign)
		else $error("differential sign bits wrong");
	property p_binary;
		@(posedge pclk) disable iff (!presetn)
		end_conv && mode != adc_pkg::MODE_DIFF |=>
			conversion_result_reg == {4'h0, $past(sar.code), 16'h0000};
	endproperty
	a_binary: assert property (p_binary)
		else $error("straight binary result wrong");
	property p_temp_timing;
		@(posedge pclk) disable iff (!presetn)
		state_reg == adc_pkg::ST_ACQ && conv_temp_reg |->
			acq_last == 5'h0F && div_last == 8'h1F;
	endproperty
	a_temp_timing: assert property (p_temp_timing)
		else $error("temperature timing not applied");
	property p_retrigger;
		@(posedge pclk) disable iff (!presetn)
		end_conv && go |=> state_reg == adc_pkg::ST_ACQ && sample_hold;
	endproperty
	a_retrigger: assert property (p_retrigger)
		else $error("held trigger did not restart");
	property p_pready_one;
		@(posedge pclk) disable iff (!presetn)
		pready_reg |=> !pready_reg;
	endproperty
	a_pready_one: assert property (p_pready_one)
		else $error("pready held past the access");
	property p_hold_len;
		@(posedge pclk) disable iff (!presetn)
		start_reg |-> $past(sample_hold) && !sample_hold;
	endproperty
	a_hold_len: assert property (p_hold_len)
		else $error("trials started without acquisition");
endmodule
`default_nettype wire

// file: verilog/adc_pkg.sv
// Constants, field layout and enumerations of the converter control block.
// Assumes a 250 MHz pclk and an APB master with 32-bit data.
`default_nettype none
package adc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_POS_CH = 8'h04;
	localparam logic [7:0] OFF_NEG_CH = 8'h08;
	localparam logic [7:0] OFF_RESULT = 8'h0C;
	localparam logic [7:0] OFF_GAIN = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	// Control field positions
	localparam int SRC_LSB = 0;
	localparam int MODE_LSB = 3;
	localparam int DIV_LSB = 5;
	localparam int ACQ_LSB = 8;
	localparam int NEG_BYP_BIT = 14;
	localparam int POS_BYP_BIT = 15;
	// Reset values: eight acquisition clocks, divider of two
	localparam logic [15:0] CONTROL_RST = 16'h0820;
	localparam logic [4:0] CHANNEL_RST = 5'h00;
	localparam logic [4:0] GAIN_RST = 5'h00;
	// Conversion timing in converter clocks
	localparam logic [4:0] EXTRA_CLOCKS = 5'h13;
	localparam logic [4:0] TEMP_ACQ_CLOCKS = 5'h10;
	localparam logic [2:0] TEMP_DIV_LOG = 3'h5;
	localparam logic [4:0] TEMP_CHANNEL = 5'h10;
	localparam logic [11:0] SAR_FIRST_TRIAL = 12'h800;
	// Input configuration
	typedef enum logic [1:0] {MODE_SINGLE, MODE_DIFF, MODE_PSEUDO} mode_t;
	// Start source
	typedef enum logic [2:0] {SRC_NONE, SRC_PIN, SRC_LOGIC, SRC_TMR0,
		SRC_TMR1, SRC_SINGLE, SRC_CONT} src_t;
	// Sequencer state
	typedef enum {ST_IDLE, ST_ACQ, ST_CONV} state_t;
endpackage
`default_nettype wire

// file: verilog/sar_if.sv
// Link between the sequencer and the bit-trial engine.
// Assumes both ends run on pclk.
`timescale 1ns/1ns
`default_nettype none
interface sar_if;
	logic start; // Load first trial
	logic tick; // Converter clock enable
	logic comp; // Input above trial level
	logic done; // Last bit decided, one cycle
	logic [11:0] code; // Trial or final code
	modport ctl (output start, output tick, output comp,
		input done, input code);
	modport eng (input start, input tick, input comp,
		output done, output code);
endinterface
`default_nettype wire

// file: verilog/sar_engine.sv
// Successive-approximation bit trial engine.
// Assumes start arrives while idle and tick is a one-cycle enable.
`timescale 1ns/1ns
`default_nettype none
module sar_engine (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Sequencer link
	sar_if.eng sar
);
	logic busy_reg; // Trials under way
	logic [3:0] bit_reg; // Bit being decided
	logic [11:0] code_reg; // Trial code
	logic done_reg; // Completion pulse

	assign sar.code = code_reg;
	assign sar.done = done_reg;

	////////////////////////////////////////////////////////////////
	// twelve bit trials
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg <= 1'b0;
			bit_reg <= 4'h0;
			code_reg <= 12'h000;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (sar.start) begin
				// Midscale first
				busy_reg <= 1'b1;
				bit_reg <= 4'hB;
				code_reg <= adc_pkg::SAR_FIRST_TRIAL;
			end else if (busy_reg && sar.tick) begin
				// Keep or drop the bit, try the next one
				code_reg[bit_reg] <= sar.comp;
				if (bit_reg == 4'h0) begin
					busy_reg <= 1'b0;
					done_reg <= 1'b1;
				end else begin
					code_reg[bit_reg - 4'h1] <= 1'b1;
					bit_reg <= bit_reg - 4'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	property p_first_trial;
		@(posedge pclk) disable iff (!presetn)
		sar.start |=> code_reg == 12'h800 && busy_reg;
	endproperty
	a_first_trial: assert property (p_first_trial)
		else $error("first trial is not midscale");
	property p_done_end;
		@(posedge pclk) disable iff (!presetn)
		done_reg |-> !busy_reg && $past(bit_reg) == 4'h0;
	endproperty
	a_done_end: assert property (p_done_end)
		else $error("done without the last bit");
endmodule
`default_nettype wire

// file: bench/adc_front_end_model.sv
// Analog front end model: an input level held during trials and a
// comparator against the trial code.
// Assumes dac_code and sample_hold come from the converter on pclk.
`timescale 1ns/1ns
`default_nettype none
module adc_front_end_model (
	// Clock
	input wire logic pclk,
	// Converter side
	input wire logic sample_hold,
	input wire logic [11:0] dac_code,
	output logic comparator_in,
	// Stimulus level
	input wire logic [11:0] level
);
	logic [11:0] held = 12'h000; // Level frozen after acquisition

	////////////////////////////////////////////////////////////////////
	// Track while sampling, hold while bits are tried
	always @(posedge pclk) begin
		if (sample_hold) begin
			held <= level;
		end
	end

	assign comparator_in = (held >= dac_code);
endmodule
`default_nettype wire

// file: bench/adc_conversion_control_tb_top.sv
// Testbench for the converter control block: APB tasks, modes,
// timing, start sources and result coding.
// Assumes the front end model and the design files are compiled first.
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_control_tb_top;
	logic pclk = 1'b0; // Bus clock
	logic presetn = 1'b0; // Reset, active low
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] trig = 4'h0; // Start sources, pin first
	logic [11:0] level = 12'h000; // Analog input level
	wire [31:0] prdata;
	wire pready, pslverr, comparator_in, sample_hold, conversion_done;
	wire pos_byp, neg_byp;
	wire [11:0] dac_code;
	wire [1:0] adc_mode;
	wire [4:0] pos_sel, neg_sel, gain;
	int n_errors = 0;
	int checked = 0;
	int cyc; // Cycles of the last wait
	logic [31:0] rd; // Last read data
	logic er; // Last error flag
	logic [11:0] lv [3] = '{12'h5A3, 12'h234, 12'hC3F};
	logic [15:0] ctl [3] = '{16'h4825, 16'h882D, 16'hC835};

	initial forever #2 pclk = ~pclk;

	adc_conversion_control i_adc_conversion_control (
		.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .external_convert_pin(trig[0]),
		.logic_array_output(trig[1]), .general_timer_zero(trig[2]),
		.general_timer_one(trig[3]), .comparator_in(comparator_in),
		.dac_code(dac_code), .sample_hold(sample_hold),
		.adc_mode(adc_mode), .pos_buffer_bypass(pos_byp),
		.neg_buffer_bypass(neg_byp),
		.positive_channel_select(pos_sel),
		.negative_channel_select(neg_sel),
		.amplifier_gain_field(gain),
		.conversion_done(conversion_done));

	adc_front_end_model i_adc_front_end_model (
		.pclk(pclk), .sample_hold(sample_hold), .dac_code(dac_code),
		.comparator_in(comparator_in), .level(level));

	////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task close_out;
		$display("Counts: checked %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Compare one value
	task check(input string name, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", name, e, g);
			n_errors++;
		end
	endtask

	// One APB transfer, setup then access until pready
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			$display("BAD pready expected 1 seen timeout");
			n_errors++;
			close_out;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Read and compare
	task rd_chk(input string name, input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h00000000);
		check(name, e, rd);
	endtask

	// Wait for a completion pulse, bounded
	task wait_done(input int lim);
		cyc = 0;
		do begin
			@(posedge pclk);
			cyc++;
		end while (conversion_done !== 1'b1 && cyc < lim);
		if (conversion_done !== 1'b1) begin
			$display("BAD done expected 1 seen timeout");
			n_errors++;
			close_out;
		end
	endtask

	// No completion pulse for a number of cycles
	task quiet(input string name, input int lim);
		logic hit;
		hit = 1'b0;
		repeat (lim) begin
			@(posedge pclk);
			if (conversion_done !== 1'b0) hit = 1'b1;
		end
		check(name, 32'h0, hit);
	endtask

	// Expected result word for a mode and a code
	function automatic logic [31:0] exp_res(input int m, input logic [11:0] c);
		logic signed [31:0] s;
		s = {{4{~c[11]}}, c ^ 12'h800, 16'h0000};
		if (m == 1) return s >>> 1;
		return {4'h0, c, 16'h0000};
	endfunction

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("control reset", 8'h00, 32'h00000820);
		rd_chk("positive reset", 8'h04, 32'h0);
		rd_chk("gain reset", 8'h10, 32'h0);
		xfer(1'b1, 8'h0C, 32'hFFFFFFFF);
		rd_chk("result read only", 8'h0C, 32'h0);
		xfer(1'b1, 8'h18, 32'hFFFFFFFF);
		check("unmapped write error", 32'h1, er);
		xfer(1'b0, 8'h18, 32'h0);
		check("unmapped read error", 32'h1, er);
		check("unmapped read data", 32'h0, rd);
		$display("Test registers done");
		// Every mode, with the amplified pair sequence
		for (int m = 0; m < 3; m++) begin
			xfer(1'b1, 8'h04, 32'(m + 1));
			xfer(1'b1, 8'h08, 32'(m + 4));
			xfer(1'b1, 8'h10, 32'(31 - m));
			level <= lv[m];
			xfer(1'b1, 8'h00, {16'h0000, ctl[m]});
			@(negedge pclk);
			check("mode pin", 32'(m), adc_mode);
			check("positive bypass", ctl[m][15], pos_byp);
			check("negative bypass", ctl[m][14], neg_byp);
			check("positive select", 32'(m + 1), pos_sel);
			check("negative select", 32'(m + 4), neg_sel);
			check("gain pin", 32'(31 - m), gain);
			wait_done(2000);
			if (m == 0) check("default timing", 1, cyc >= 54 && cyc <= 60);
			rd_chk("status done", 8'h14, 32'h1);
			rd_chk("result", 8'h0C, exp_res(m, lv[m]));
			rd_chk("status cleared", 8'h14, 32'h0);
		end
		$display("Test modes done");
		// Temperature channel timing, then user timing again
		xfer(1'b1, 8'h04, 32'h10);
		xfer(1'b1, 8'h00, 32'h0825);
		wait_done(3000);
		check("temperature timing", 1, cyc >= 1120 && cyc <= 1130);
		xfer(1'b1, 8'h04, 32'h0);
		xfer(1'b1, 8'h00, 32'h0825);
		wait_done(200);
		check("timing reverts", 1, cyc >= 54 && cyc <= 60);
		$display("Test temperature done");
		// Each hardware source, others ignored, restart while high
		level <= 12'h3C7;
		for (int s = 1; s < 5; s++) begin
			xfer(1'b1, 8'h00, 32'h0820 | s);
			trig <= 4'hF ^ (4'h1 << (s - 1));
			quiet("other sources ignored", 80);
			trig <= 4'h1 << (s - 1);
			wait_done(100);
			trig <= 4'h0;
			wait_done(75);
			quiet("stops when released", 80);
			rd_chk("triggered result", 8'h0C, 32'h03C70000);
		end
		$display("Test triggers done");
		// Continuous conversion, then stop
		xfer(1'b1, 8'h00, 32'h0826);
		wait_done(100);
		rd_chk("status busy", 8'h14, 32'h3);
		wait_done(75);
		xfer(1'b1, 8'h00, 32'h0820);
		repeat (70) @(posedge pclk);
		quiet("continuous stopped", 80);
		$display("Test continuous done");
		close_out;
	end
endmodule
`default_nettype wire
